// >>> common/panel_pkg.sv
package panel_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int DEB_MS = 10;
  localparam int DEB_TICKS = DEB_MS / TICK_MS;
  localparam int HOLD_MS = 3000;
  localparam int HOLD_TICKS = HOLD_MS / TICK_MS;
  localparam int REP_DLY_MS = 500;
  localparam int REP_DLY_TICKS = REP_DLY_MS / TICK_MS;
  localparam int REP_SLOW_MS = 200;
  localparam int REP_SLOW_TICKS = REP_SLOW_MS / TICK_MS;
  localparam int REP_FAST_MS = 50;
  localparam int REP_FAST_TICKS = REP_FAST_MS / TICK_MS;
  localparam int REP_ACC_MS = 2000;
  localparam int REP_ACC_TICKS = REP_ACC_MS / TICK_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_TICKS = BLINK_MS / TICK_MS;
  localparam int NUM_MODES = 7;
  localparam int DIGITS = 5;
  localparam logic [15:0] DEF_PAR_MAX = 16'h0063;
  localparam logic [15:0] UNLOCK_CODE = 16'h020f;
  localparam logic [15:0] SPD_TEST_CTRL = 16'h0002;
  localparam logic [15:0] JOG_CTRL = 16'h0005;
  localparam logic [15:0] FORCED_ON = 16'h0001;
  localparam logic signed [16:0] NEG_SIGN_LIM = -17'sd10000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SPEED = 8'h08;
  localparam logic [7:0] OFS_KEYS = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_LOCK_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] OP_SAVE = 2'h0;
  localparam logic [1:0] OP_FACTORY = 2'h1;
  localparam logic [1:0] OP_SOFT_RST = 2'h2;
  localparam logic [4:0] CH_MINUS = 5'h0a;
  localparam logic [4:0] CH_BLANK = 5'h0b;
  localparam logic [4:0] CH_P = 5'h0c;
  localparam logic [4:0] CH_A = 5'h0d;
  localparam logic [4:0] CH_E = 5'h0e;
  localparam logic [4:0] CH_R = 5'h0f;
  localparam logic [4:0] CH_D = 5'h10;
  localparam logic [4:0] CH_N = 5'h11;
  localparam logic [4:0] CH_J = 5'h12;
  localparam logic [4:0] CH_S = 5'h13;
  localparam logic [4:0] CH_F = 5'h14;
  localparam logic [4:0] CH_O = 5'h15;

  typedef struct packed {
    logic up;
    logic down;
    logic ret;
    logic ent;
  } key_s;

  typedef logic [DIGITS-1:0][4:0] chars_t;
  typedef logic [DIGITS-1:0][7:0] seg_t;

  typedef enum logic [2:0] {
    M_MON = 3'h0, M_PA = 3'h1, M_FN = 3'h2, M_MGT = 3'h3,
    M_SPD = 3'h4, M_JOG = 3'h5, M_AUX = 3'h6
  } mode_e;

  typedef enum logic [3:0] {
    S_TOP = 4'h0, S_MON_SEL = 4'h1, S_MON_VAL = 4'h2, S_PAR_SEL = 4'h3,
    S_PAR_EDIT = 4'h4, S_MGT_SEL = 4'h5, S_MGT_BUSY = 4'h6, S_MGT_DONE = 4'h7,
    S_SPEED = 4'h8, S_JOG = 4'h9, S_AUX = 4'ha
  } state_e;
endpackage : panel_pkg

// >>> rtl/front_panel_menu_controller.sv
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Numbers show on five digits, some items led by a prefix character.
// - Rightmost decimal point flashes while an alarm is active.
// - Negative value lights its decimal point; above -10000 and with no prefix character also a leading minus.
// - Up increments, down decrements, return goes back, enter confirms.
// - Holding up or down repeats the step, faster the longer it is held.
// - Power lamp follows main power; run lamp follows drive enabled.
// - Top level cycles seven modes; enter opens level two, return comes back.
// - Monitor: up/down pick item, enter shows value, return backs out.
// - Parameters: pick number, enter shows value, edit, enter commits at once.
// - Rightmost decimal point lit while an edit is uncommitted, cleared on commit.
// - Return during an edit discards it and goes back a level.
// - Only parameters up to 99 reachable unless password holds 527.
// - Management picks one of three commands; runs after enter held over 3 s.
// - Edits touch the working table; save copies it to EEPROM.
// - Factory restore loads factory values into table and EEPROM.
// - Soft reset restarts the drive processor like a power cycle.
// - Command shows busy, then done on success or error on failure.
// - Speed test needs control mode 2 and forced input 1; keys set speed.
// - Jog needs control mode 5; up held runs forward at jog speed.
// - In jog, down held runs reverse at jog speed, stops on release.
module front_panel_menu_controller
  import panel_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int NUM_PAR = 128,
  parameter logic signed [15:0] SPEED_MAX = 16'sh1388
)(
  input wire logic clk,
  input wire logic rst,
  input wire key_s key_raw,
  output seg_t seg,
  output logic power_indicator,
  output logic run_indicator,
  input wire logic main_power_ok,
  input wire logic drive_enabled,
  input wire logic alarm_active,
  output logic [3:0] mon_sel,
  input wire logic signed [15:0] mon_value,
  output logic [7:0] par_addr,
  input wire logic signed [15:0] par_rdata,
  output logic par_we,
  output logic signed [15:0] par_wdata,
  input wire logic [15:0] control_mode_param,
  input wire logic [15:0] forced_input_param,
  input wire logic signed [15:0] jog_speed_param,
  input wire logic [15:0] password_param,
  output logic mgmt_req,
  output logic [1:0] mgmt_op,
  input wire logic mgmt_done,
  input wire logic mgmt_ok,
  output logic speed_test_on,
  output logic jog_on,
  output logic signed [15:0] speed_cmd,
  output logic jog_fwd,
  output logic jog_rev,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  function automatic chars_t to_chars(input logic [16:0] m);
    chars_t c;
    logic [16:0] r;
    r = m;
    for (int i = 0; i < DIGITS; i++)
    begin
      c[i] = 5'(r % 17'd10);
      r = r / 17'd10;
    end
    return c;
  endfunction : to_chars

  function automatic logic [6:0] enc7(input logic [4:0] ch);
    case (ch)
      5'h00: enc7 = 7'h3f;
      5'h01: enc7 = 7'h06;
      5'h02: enc7 = 7'h5b;
      5'h03: enc7 = 7'h4f;
      5'h04: enc7 = 7'h66;
      5'h05, CH_S: enc7 = 7'h6d;
      5'h06: enc7 = 7'h7d;
      5'h07: enc7 = 7'h07;
      5'h08: enc7 = 7'h7f;
      5'h09: enc7 = 7'h6f;
      CH_MINUS: enc7 = 7'h40;
      CH_P: enc7 = 7'h73;
      CH_A: enc7 = 7'h77;
      CH_E: enc7 = 7'h79;
      CH_R: enc7 = 7'h50;
      CH_D: enc7 = 7'h5e;
      CH_N: enc7 = 7'h54;
      CH_J: enc7 = 7'h1e;
      CH_F: enc7 = 7'h71;
      CH_O: enc7 = 7'h5c;
      default: enc7 = 7'h00;
    endcase
  endfunction : enc7

  // Millisecond enable; all panel timing counts these pulses
  logic [31:0] div_ff;
  logic tick;
  assign tick = (div_ff == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_ff <= '0;
    else
      div_ff <= tick ? '0 : div_ff + 32'h1;
  end

  logic [31:0] ctrl_ff;
  logic [3:0] raw, stab_ff, prev_ff, press, held;
  logic [3:0][7:0] deb_ff;
  assign raw = key_raw;
  // Locked panel ignores keys entirely; stable state keeps tracking
  assign held = ctrl_ff[CTRL_LOCK_BIT] ? 4'h0 : stab_ff;
  assign press = held & ~prev_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stab_ff <= '0;
      deb_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      prev_ff <= held;
      for (int i = 0; i < 4; i++)
      begin
        if (raw[i] == stab_ff[i])
          deb_ff[i] <= '0;
        else if (tick && deb_ff[i] == 8'(DEB_TICKS - 1))
        begin
          stab_ff[i] <= raw[i];
          deb_ff[i] <= '0;
        end
        else if (tick)
          deb_ff[i] <= deb_ff[i] + 8'h1;
      end
    end
  end

  key_s kh, kp;
  assign kh = held;
  assign kp = press;

  // Auto repeat: first step on the press, then slow, then fast
  logic [15:0] rep_age_ff, rep_cnt_ff;
  logic rep_hit, up_step, dn_step;
  logic [15:0] rep_per;
  assign rep_per = (rep_age_ff >= 16'(REP_ACC_TICKS)) ? 16'(REP_FAST_TICKS) : 16'(REP_SLOW_TICKS);
  assign rep_hit = tick && (kh.up ^ kh.down) && rep_age_ff >= 16'(REP_DLY_TICKS) && rep_cnt_ff >= rep_per - 16'h1;
  assign up_step = kp.up | (kh.up & ~kh.down & rep_hit);
  assign dn_step = kp.down | (kh.down & ~kh.up & rep_hit);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rep_age_ff <= '0;
      rep_cnt_ff <= '0;
    end
    else if (!(kh.up ^ kh.down))
    begin
      rep_age_ff <= '0;
      rep_cnt_ff <= '0;
    end
    else if (tick)
    begin
      if (rep_age_ff != 16'hffff)
        rep_age_ff <= rep_age_ff + 16'h1;
      rep_cnt_ff <= rep_hit ? '0 : rep_cnt_ff + 16'h1;
    end
  end

  state_e st_ff;
  mode_e mode_ff;
  logic [7:0] idx_ff;
  logic [3:0] mon_ff;
  logic [1:0] mgt_sel_ff;
  logic [15:0] hold_ff;
  logic signed [15:0] edit_ff, spd_ff;
  logic dirty_ff, ok_ff, req_ff, we_ff, bank_ff;
  logic [7:0] par_max;
  logic spd_ok, jog_ok;
  assign par_max = (password_param == UNLOCK_CODE) ? 8'(NUM_PAR - 1) : DEF_PAR_MAX[7:0];
  assign spd_ok = control_mode_param == SPD_TEST_CTRL && forced_input_param == FORCED_ON;
  assign jog_ok = control_mode_param == JOG_CTRL;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_ff <= '0;
    else if (st_ff != S_MGT_SEL || !kh.ent)
      hold_ff <= '0;
    else if (tick && hold_ff <= 16'(HOLD_TICKS))
      hold_ff <= hold_ff + 16'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= S_TOP;
      mode_ff <= M_MON;
      idx_ff <= '0;
      mon_ff <= '0;
      mgt_sel_ff <= OP_SAVE;
      edit_ff <= '0;
      spd_ff <= '0;
      dirty_ff <= 1'b0;
      ok_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      bank_ff <= 1'b0;
    end
    else
    begin
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      case (st_ff)
        S_TOP:
        begin
          if (up_step)
            mode_ff <= (mode_ff == M_AUX) ? M_MON : mode_e'(mode_ff + 3'h1);
          else if (dn_step)
            mode_ff <= (mode_ff == M_MON) ? M_AUX : mode_e'(mode_ff - 3'h1);
          else if (kp.ent)
          begin
            idx_ff <= '0;
            bank_ff <= (mode_ff == M_FN);
            case (mode_ff)
              M_MON: st_ff <= S_MON_SEL;
              M_PA, M_FN: st_ff <= S_PAR_SEL;
              M_MGT: st_ff <= S_MGT_SEL;
              M_SPD: st_ff <= spd_ok ? S_SPEED : S_TOP;
              M_JOG: st_ff <= jog_ok ? S_JOG : S_TOP;
              default: st_ff <= S_AUX;
            endcase
            spd_ff <= '0;
          end
        end
        S_MON_SEL:
        begin
          if (up_step)
            mon_ff <= mon_ff + 4'h1;
          else if (dn_step)
            mon_ff <= mon_ff - 4'h1;
          else if (kp.ent)
            st_ff <= S_MON_VAL;
          else if (kp.ret)
            st_ff <= S_TOP;
        end
        S_MON_VAL:
          if (kp.ret)
            st_ff <= S_MON_SEL;
        S_PAR_SEL:
        begin
          if (up_step)
            idx_ff <= (idx_ff >= par_max) ? 8'h00 : idx_ff + 8'h1;
          else if (dn_step)
            idx_ff <= (idx_ff == 8'h00 || idx_ff > par_max) ? par_max : idx_ff - 8'h1;
          else if (kp.ent)
          begin
            edit_ff <= par_rdata;
            dirty_ff <= 1'b0;
            st_ff <= S_PAR_EDIT;
          end
          else if (kp.ret)
            st_ff <= S_TOP;
        end
        S_PAR_EDIT:
        begin
          if (kp.ret)
          begin
            dirty_ff <= 1'b0;
            st_ff <= S_PAR_SEL;
          end
          else if (kp.ent)
          begin
            we_ff <= 1'b1;
            dirty_ff <= 1'b0;
          end
          else if (up_step)
          begin
            edit_ff <= edit_ff + 16'sh1;
            dirty_ff <= 1'b1;
          end
          else if (dn_step)
          begin
            edit_ff <= edit_ff - 16'sh1;
            dirty_ff <= 1'b1;
          end
        end
        S_MGT_SEL:
        begin
          if (up_step)
            mgt_sel_ff <= (mgt_sel_ff == OP_SOFT_RST) ? OP_SAVE : mgt_sel_ff + 2'h1;
          else if (dn_step)
            mgt_sel_ff <= (mgt_sel_ff == OP_SAVE) ? OP_SOFT_RST : mgt_sel_ff - 2'h1;
          else if (kp.ret)
            st_ff <= S_TOP;
          else if (hold_ff > 16'(HOLD_TICKS))
          begin
            req_ff <= 1'b1;
            st_ff <= S_MGT_BUSY;
          end
        end
        S_MGT_BUSY:
          if (mgmt_done)
          begin
            ok_ff <= mgmt_ok;
            st_ff <= S_MGT_DONE;
          end
        S_MGT_DONE:
          if (kp.ret || kp.ent)
            st_ff <= S_MGT_SEL;
        S_SPEED:
        begin
          if (up_step && spd_ff < SPEED_MAX)
            spd_ff <= spd_ff + 16'sh1;
          else if (dn_step && spd_ff > -SPEED_MAX)
            spd_ff <= spd_ff - 16'sh1;
          else if (kp.ret)
          begin
            spd_ff <= '0;
            st_ff <= S_TOP;
          end
        end
        S_JOG, S_AUX:
          if (kp.ret)
            st_ff <= S_TOP;
        default: st_ff <= S_TOP;
      endcase
    end
  end

  // Outputs to the drive side, registered except speed_test_on and jog_on, decoded from st_ff
  logic jf_ff, jr_ff, pw_ff, run_ff;
  logic signed [15:0] cmd_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      jf_ff <= 1'b0;
      jr_ff <= 1'b0;
      cmd_ff <= '0;
      pw_ff <= 1'b0;
      run_ff <= 1'b0;
    end
    else
    begin
      jf_ff <= (st_ff == S_JOG) && kh.up && !kh.down;
      jr_ff <= (st_ff == S_JOG) && kh.down && !kh.up;
      if (st_ff == S_JOG)
        cmd_ff <= (kh.up ^ kh.down) ? jog_speed_param : 16'sh0;
      else
        cmd_ff <= (st_ff == S_SPEED) ? spd_ff : 16'sh0;
      pw_ff <= main_power_ok;
      run_ff <= drive_enabled;
    end
  end
  assign jog_fwd = jf_ff;
  assign jog_rev = jr_ff;
  assign speed_cmd = cmd_ff;
  assign power_indicator = pw_ff;
  assign run_indicator = run_ff;
  assign mgmt_req = req_ff;
  assign mgmt_op = mgt_sel_ff;
  assign par_we = we_ff;
  assign par_wdata = edit_ff;
  assign par_addr = {bank_ff, idx_ff[6:0]};
  assign mon_sel = mon_ff;
  assign speed_test_on = (st_ff == S_SPEED);
  assign jog_on = (st_ff == S_JOG);

  // Display
  logic [15:0] blink_ff;
  logic blink_on_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      blink_ff <= '0;
      blink_on_ff <= 1'b0;
    end
    else if (tick)
    begin
      blink_ff <= (blink_ff == 16'(BLINK_TICKS - 1)) ? '0 : blink_ff + 16'h1;
      if (blink_ff == 16'(BLINK_TICKS - 1))
        blink_on_ff <= ~blink_on_ff;
    end
  end

  chars_t ch, dig;
  logic [4:0] pre;
  logic signed [16:0] num;
  logic shownum, neg;
  always_comb
  begin
    ch = {DIGITS{CH_BLANK}};
    pre = CH_BLANK;
    num = '0;
    shownum = 1'b1;
    case (st_ff)
      S_TOP:
      begin
        shownum = 1'b0;
        ch[3] = CH_MINUS;
        case (mode_ff)
          M_MON: ch[4] = CH_D;
          M_PA: ch[4] = CH_P;
          M_FN: ch[4] = CH_F;
          M_MGT: ch[4] = CH_E;
          M_SPD: ch[4] = CH_S;
          M_JOG: ch[4] = CH_J;
          default: ch[4] = CH_A;
        endcase
      end
      S_MON_SEL:
      begin
        pre = CH_D;
        num = 17'(mon_ff);
      end
      S_MON_VAL: num = 17'(mon_value);
      S_PAR_SEL:
      begin
        pre = bank_ff ? CH_F : CH_P;
        num = 17'(idx_ff);
      end
      S_PAR_EDIT: num = 17'(edit_ff);
      S_MGT_SEL:
      begin
        pre = CH_E;
        num = 17'(mgt_sel_ff);
      end
      S_MGT_BUSY:
      begin
        shownum = 1'b0;
        ch = {CH_S, CH_MINUS, CH_MINUS, CH_MINUS, CH_MINUS};
      end
      S_MGT_DONE:
      begin
        shownum = 1'b0;
        ch = ok_ff ? {CH_BLANK, CH_D, CH_O, CH_N, CH_E} : {CH_BLANK, CH_BLANK, CH_E, CH_R, CH_R};
      end
      S_SPEED:
      begin
        pre = CH_S;
        num = 17'(spd_ff);
      end
      S_JOG:
      begin
        pre = CH_J;
        num = 17'(jog_speed_param);
      end
      default: shownum = 1'b0;
    endcase
    neg = shownum && num < 0;
    dig = to_chars(neg ? 17'(-num) : 17'(num));
    if (shownum)
    begin
      ch = dig;
      if (pre != CH_BLANK)
        ch[4] = pre;
      else if (neg && num > NEG_SIGN_LIM)
        ch[4] = CH_MINUS;
    end
  end

  seg_t seg_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seg_ff <= '0;
    else
    begin
      for (int i = 0; i < DIGITS; i++)
        seg_ff[i] <= {1'b0, enc7(ch[i])};
      seg_ff[4][7] <= neg;
      seg_ff[0][7] <= dirty_ff | (alarm_active & blink_on_ff);
    end
  end
  assign seg = seg_ff;

  // Register slave; write address and data may arrive in either order
  logic aw_got_ff, w_got_ff, bv_ff, rv_ff;
  logic [7:0] aw_ff;
  logic [31:0] wd_ff, rd_ff;
  logic [1:0] br_ff, rr_ff;
  logic [31:0] rd_mux;
  assign awready = !aw_got_ff && !bv_ff;
  assign wready = !w_got_ff && !bv_ff;
  assign arready = !rv_ff;
  always_comb
  begin
    case (araddr)
      OFS_CTRL: rd_mux = ctrl_ff;
      OFS_STATUS: rd_mux = {23'h0, ok_ff, dirty_ff, mode_ff, st_ff};
      OFS_SPEED: rd_mux = 32'(cmd_ff);
      OFS_KEYS: rd_mux = {28'h0, stab_ff};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      aw_ff <= '0;
      wd_ff <= '0;
      rd_ff <= '0;
      br_ff <= RESP_OKAY;
      rr_ff <= RESP_OKAY;
      ctrl_ff <= CTRL_RST;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_ff <= 1'b1;
        aw_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        wd_ff <= wstrb[0] ? wdata : ctrl_ff;
        w_got_ff <= 1'b1;
      end
      if (aw_got_ff && w_got_ff)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bv_ff <= 1'b1;
        br_ff <= (aw_ff == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
        if (aw_ff == OFS_CTRL)
          ctrl_ff <= {31'h0, wd_ff[CTRL_LOCK_BIT]};
      end
      else if (bv_ff && bready)
        bv_ff <= 1'b0;
      if (arvalid && arready)
      begin
        rv_ff <= 1'b1;
        rd_ff <= rd_mux;
        rr_ff <= (araddr[1:0] == 2'h0 && araddr <= OFS_KEYS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rv_ff && rready)
        rv_ff <= 1'b0;
    end
  end
  assign bvalid = bv_ff;
  assign bresp = br_ff;
  assign rvalid = rv_ff;
  assign rdata = rd_ff;
  assign rresp = rr_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_edit_commit;
    st_ff == S_PAR_EDIT && kp.ent && !kp.ret;
  endsequence
  sequence s_edit_cancel;
    st_ff == S_PAR_EDIT && kp.ret;
  endsequence
  sequence s_cmd_issued;
    req_ff ##1 st_ff == S_MGT_BUSY;
  endsequence
  chk_commit_write: assert property (s_edit_commit |=> we_ff && !dirty_ff && par_wdata == $past(edit_ff))
    else $error("commit did not write");
  chk_dirty_point: assert property (st_ff == S_PAR_EDIT && dirty_ff && !alarm_active |=> seg[0][7])
    else $error("edit point dark");
  chk_cancel_discard: assert property (s_edit_cancel |=> st_ff == S_PAR_SEL && !we_ff ##1 !we_ff)
    else $error("cancel wrote value");
  chk_mode_wrap: assert property (st_ff == S_TOP && mode_ff == M_AUX && up_step |=> mode_ff == M_MON)
    else $error("mode did not wrap");
  chk_index_limit: assert property (password_param != UNLOCK_CODE && st_ff == S_PAR_SEL |-> idx_ff <= DEF_PAR_MAX[7:0])
    else $error("index beyond locked range");
  chk_hold_time: assert property ($rose(req_ff) |-> $past(hold_ff) > 16'(HOLD_TICKS))
    else $error("command before hold time");
  chk_busy_show: assert property (s_cmd_issued |-> seg[4][6:0] == 7'h6d)
    else $error("busy not shown");
  chk_jog_fwd: assert property (st_ff == S_JOG && kh.up && !kh.down |=> jog_fwd && !jog_rev)
    else $error("jog forward missing");
  chk_jog_rev: assert property (st_ff == S_JOG && kh.down && !kh.up |=> jog_rev && !jog_fwd)
    else $error("jog reverse wrong");
  chk_jog_stop: assert property (!(st_ff == S_JOG && kh.down && !kh.up) |=> !jog_rev)
    else $error("jog reverse not stopped");
  chk_lamps: assert property ((main_power_ok && drive_enabled) [*2] |-> power_indicator && run_indicator)
    else $error("lamps not following");
endmodule : front_panel_menu_controller

// >>> tb/operator_side_model.sv
`timescale 1ns/1ps
module operator_side_model
  import panel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] par_addr,
  output logic signed [15:0] par_rdata,
  input wire logic par_we,
  input wire logic signed [15:0] par_wdata,
  input wire logic mgmt_req,
  output logic mgmt_done,
  output logic mgmt_ok
);
  logic signed [15:0] table_ff [256];
  logic [7:0] wait_ff;
  assign par_rdata = table_ff[par_addr];
  assign mgmt_ok = 1'b1;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 256; i++)
        table_ff[i] <= 16'sh0064;
    end
    else if (par_we)
    begin
      table_ff[par_addr] <= par_wdata;
    end
  end
  // EEPROM access is slow, so done comes well after the request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_ff <= 8'h00;
      mgmt_done <= 1'b0;
    end
    else
    begin
      mgmt_done <= (wait_ff == 8'h01);
      if (mgmt_req)
        wait_ff <= 8'hc8;
      else if (wait_ff != 8'h00)
        wait_ff <= wait_ff - 8'h01;
    end
  end
endmodule : operator_side_model

// >>> tb/front_panel_menu_controller_bench.sv
`timescale 1ns/1ps
module front_panel_menu_controller_bench;
  import panel_pkg::*;
  localparam logic [3:0] KUP = 4'h8, KDN = 4'h4, KRT = 4'h2, KEN = 4'h1;
  logic clk, rst, main_power_ok, drive_enabled, alarm_active, par_we, mgmt_req, mgmt_done, mgmt_ok;
  logic speed_test_on, jog_on, jog_fwd, jog_rev, power_indicator, run_indicator;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  key_s key_raw;
  seg_t seg;
  logic [3:0] mon_sel, wstrb;
  logic [7:0] par_addr, awaddr, araddr;
  logic [1:0] mgmt_op, bresp, rresp, op_seen, resp;
  logic signed [15:0] mon_value, par_rdata, par_wdata, jog_speed_param, speed_cmd, wdata_seen;
  logic [15:0] control_mode_param, forced_input_param, password_param;
  logic [31:0] wdata, rdata, rd;
  int mismatches, check_count, we_count, req_count;

  front_panel_menu_controller #(.TICK_CYCLES(4)) front_panel_menu_controller_i (.clk, .rst, .key_raw, .seg,
    .power_indicator, .run_indicator, .main_power_ok, .drive_enabled, .alarm_active, .mon_sel, .mon_value,
    .par_addr, .par_rdata, .par_we, .par_wdata, .control_mode_param, .forced_input_param, .jog_speed_param,
    .password_param, .mgmt_req, .mgmt_op, .mgmt_done, .mgmt_ok, .speed_test_on, .jog_on, .speed_cmd, .jog_fwd,
    .jog_rev, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  operator_side_model operator_side_model_i (.clk, .rst, .par_addr, .par_rdata, .par_we, .par_wdata,
    .mgmt_req, .mgmt_done, .mgmt_ok);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (par_we === 1'b1)
    begin
      we_count++;
      wdata_seen = par_wdata;
    end
    if (mgmt_req === 1'b1)
    begin
      req_count++;
      op_seen = mgmt_op;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tap(input logic [3:0] k);
    key_raw <= k;
    repeat (80) @(posedge clk);
    key_raw <= 4'h0;
    repeat (80) @(posedge clk);
  endtask : tap

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic chk_state(input state_e st, input mode_e md);
    axi_rd(OFS_STATUS);
    chk("status", {25'h0, md, st}, {25'h0, rd[6:0]});
  endtask : chk_state

  task automatic t_regs;
    main_power_ok <= 1'b1;
    drive_enabled <= 1'b1;
    axi_wr(OFS_CTRL, 32'h0000_0000);
    chk("power lamp", 32'h1, 32'(power_indicator));
    chk("run lamp", 32'h1, 32'(run_indicator));
    chk("ctrl resp", 32'(RESP_OKAY), 32'(resp));
    axi_wr(OFS_STATUS, 32'h0000_0001);
    chk("ro resp", 32'(RESP_SLVERR), 32'(resp));
    axi_rd(8'h40);
    chk("hole resp", 32'(RESP_SLVERR), 32'(resp));
  endtask : t_regs

  task automatic t_param;
    tap(KUP);
    tap(KEN);
    chk_state(S_PAR_SEL, M_PA);
    tap(KEN);
    tap(KUP);
    chk("edit dp", 32'h1, 32'(seg[0][7]));
    tap(KEN);
    chk("commit value", 32'h0000_0065, {16'h0, wdata_seen});
    chk("commit dp", 32'h0, 32'(seg[0][7]));
    tap(KUP);
    tap(KRT);
    chk("commits", 32'h1, 32'(we_count));
    chk("kept value", 32'h0000_0065, {16'h0, par_rdata});
    chk_state(S_PAR_SEL, M_PA);
    tap(KRT);
  endtask : t_param

  task automatic t_mgmt;
    tap(KUP);
    tap(KUP);
    tap(KEN);
    key_raw <= KEN;
    repeat (11000) @(posedge clk);
    chk("early req", 32'h0, 32'(req_count));
    repeat (1400) @(posedge clk);
    chk("req", 32'h1, 32'(req_count));
    chk("op", 32'(OP_SAVE), 32'(op_seen));
    key_raw <= 4'h0;
    repeat (400) @(posedge clk);
    chk_state(S_MGT_DONE, M_MGT);
    chk("ok", 32'h1, 32'(rd[8]));
    tap(KRT);
    tap(KRT);
  endtask : t_mgmt

  task automatic t_speed;
    control_mode_param <= 16'h0002;
    forced_input_param <= 16'h0001;
    tap(KUP);
    tap(KEN);
    chk("speed on", 32'h1, 32'(speed_test_on));
    tap(KDN);
    axi_rd(OFS_SPEED);
    chk("speed", 32'hffff_ffff, rd);
    chk("neg dp", 32'h1, 32'(seg[4][7]));
    alarm_active <= 1'b1;
    @(posedge seg[0][7]);
    repeat (2) @(posedge clk);
    chk("alarm dp on", 32'h1, 32'(seg[0][7]));
    repeat (1000) @(posedge clk);
    chk("alarm dp off", 32'h0, 32'(seg[0][7]));
    alarm_active <= 1'b0;
    tap(KRT);
    chk("speed off", 32'h0, 32'(speed_test_on));
  endtask : t_speed

  task automatic t_jog;
    control_mode_param <= 16'h0005;
    tap(KUP);
    tap(KEN);
    key_raw <= KUP;
    repeat (80) @(posedge clk);
    chk("fwd", 32'h1, 32'(jog_fwd));
    tap(KDN);
    chk("fwd stop", 32'h0, 32'(jog_fwd));
    key_raw <= KDN;
    repeat (80) @(posedge clk);
    chk("rev", 32'h1, 32'(jog_rev));
    tap(KRT);
    chk("rev stop", 32'h0, 32'(jog_rev));
  endtask : t_jog

  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    rst = 1'b1;
    key_raw = 4'h0;
    {main_power_ok, drive_enabled, alarm_active, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wstrb, wdata} = '0;
    {mon_value, jog_speed_param, control_mode_param, forced_input_param, password_param} = '0;
    wstrb = 4'hf;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_param;
    t_mgmt;
    t_speed;
    t_jog;
    wrap_up;
  end

  initial
  begin
    #1_500_000;
    mismatches++;
    wrap_up;
  end
endmodule : front_panel_menu_controller_bench
